/* File: rtl/spl_strap_latch.sv */
// strap latch: captures boot straps at reset release and serves them to software
// Functional notes
// R1: on reset release latch each of five strap inputs as one bit
// R2: capture follows power-on, watchdog or brownout reset release
// R3: latched bits stay fixed until power-down, whatever the pins do; the code reloads them at every reset release
// R4: during reset each strap input gets its weak default pull
// R5: after reset release strap pins act as ordinary function pins
// R6: latched strap bits readable through a read-only status register
// R7: supply strap 0 selects 3.3 V, 1 selects 1.8 V
// R8: strap A high boots flash; A and B low select download boot
// R9: log strap high enables boot log on first serial tx line
// R10: log strap picks sdio sample edge, fifth strap picks output edge
// R11: firmware may override voltage and sdio edge selection after boot
// R12: outside party never holds supply strap high at power-up
// R13: outside party drives straps to wanted levels at power-on
// R14: enable input active high; low keeps module disabled
// R15: synchronise pins, load once when reset deasserts, never again; the code loads again at each later reset release
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`include "spl_regs.svh"
module spl_strap_latch (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // reset sources and module enable
  input wire logic por_rst,
  input wire logic wdt_rst,
  input wire logic bod_rst,
  input wire logic module_en,
  // strap pins, levels from the pads
  input wire spl_pkg::spl_straps_t strap_in,
  // pad pull control and pin function select
  output logic [4:0] pull_up_en,
  output logic [4:0] pull_dn_en,
  output logic pins_normal_func,
  // register port
  input wire logic [`SPL_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // configuration to boot logic
  output spl_pkg::spl_cfg_t cfg_out,
  output logic boot_log_en,
  output logic run_en
);
  import spl_pkg::*;

  // ==========================================================
  // reset combination
  // ==========================================================
  logic sys_rst;
  assign sys_rst = srst | por_rst | wdt_rst | bod_rst | ~module_en; // [R2] [R14]

  // ==========================================================
  // pin synchroniser
  // ==========================================================
  logic [4:0] pins_sync;
  spl_sync #(
    .WIDTH(5)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .d_in(strap_in),
    .q_out(pins_sync)
  ); // [R15]

  // ==========================================================
  // capture sequencer
  // ==========================================================
  spl_state_t state_ff;
  spl_state_t nxt_state;
  logic [2:0] settle_ff;
  logic load_pulse;

  // cycles since release; the release sequence must be done before it saturates
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      settle_ff <= 3'h0;
    end else if (settle_ff != 3'h7) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SPL_ST_RESET: begin
        if (!sys_rst) begin
          nxt_state = SPL_ST_LOAD;
        end
      end
      SPL_ST_LOAD: begin
        nxt_state = SPL_ST_HOLD;
      end
      SPL_ST_HOLD: begin
        nxt_state = SPL_ST_HOLD;
      end
      default: begin
        nxt_state = SPL_ST_RESET;
      end
    endcase
  end

  // a reset while holding returns to RESET and reloads: straps follow each boot
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= SPL_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // load in the single cycle in which reset deasserts
  assign load_pulse = (state_ff == SPL_ST_RESET) && !sys_rst; // [R15]

  // ==========================================================
  // strap latch
  // ==========================================================
  logic [4:0] strap_ff;

  // held apart from srst so power-down is the only real clear
  always_ff @(posedge core_clk) begin
    if (load_pulse) begin
      strap_ff <= pins_sync; // [R1] [R15]
    end
  end // [R3]

  // ==========================================================
  // pad pulls and pin function
  // ==========================================================
  localparam logic [4:0] PULL_DEF = `SPL_PULL_DEFAULT;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pull_up_en <= PULL_DEF; // [R4]
      pull_dn_en <= ~PULL_DEF; // [R4]
      pins_normal_func <= 1'b0;
    end else if (state_ff != SPL_ST_RESET) begin
      pull_up_en <= 5'h00;
      pull_dn_en <= 5'h00;
      pins_normal_func <= 1'b1; // [R5]
    end
  end

  // ==========================================================
  // firmware override register
  // ==========================================================
  logic [7:0] ovr_ff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ovr_ff <= `SPL_OVR_RESET;
    end else if (reg_wr && reg_addr == `SPL_OFS_OVR && state_ff == SPL_ST_HOLD) begin
      ovr_ff <= reg_wdata; // [R11]
    end
  end

  // ==========================================================
  // decoded configuration
  // ==========================================================
  spl_cfg_t nxt_cfg;
  logic [4:0] eff_bits;

  always_comb begin
    eff_bits = strap_ff;
    if (ovr_ff[`SPL_BIT_OVR_VEN]) begin
      eff_bits[`SPL_BIT_VSEL] = ovr_ff[`SPL_BIT_VSEL]; // [R11]
    end
    if (ovr_ff[`SPL_BIT_OVR_SEN]) begin
      eff_bits[`SPL_BIT_LOG] = ovr_ff[`SPL_BIT_LOG]; // [R11]
    end
    if (ovr_ff[`SPL_BIT_OVR_OEN]) begin
      eff_bits[`SPL_BIT_OEDGE] = ovr_ff[`SPL_BIT_OEDGE]; // [R11]
    end
    nxt_cfg.vsel_1v8 = eff_bits[`SPL_BIT_VSEL]; // [R7]
    if (strap_ff[`SPL_BIT_BOOTA]) begin
      nxt_cfg.boot_src = SPL_BOOT_FLASH; // [R8]
    end else if (!strap_ff[`SPL_BIT_BOOTB]) begin
      nxt_cfg.boot_src = SPL_BOOT_DOWNLOAD; // [R8]
    end else begin
      nxt_cfg.boot_src = SPL_BOOT_OTHER;
    end
    // the log choice is the captured strap; override only moves the sdio edge
    nxt_cfg.log_en = strap_ff[`SPL_BIT_LOG]; // [R9]
    nxt_cfg.sdio_sample_rise = eff_bits[`SPL_BIT_LOG]; // [R10]
    nxt_cfg.sdio_output_rise = eff_bits[`SPL_BIT_OEDGE]; // [R10]
  end

  always_ff @(posedge core_clk) begin
    if (state_ff != SPL_ST_HOLD) begin
      cfg_out <= '0;
      boot_log_en <= 1'b0;
    end else begin
      cfg_out <= nxt_cfg;
      boot_log_en <= nxt_cfg.log_en; // [R9]
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      run_en <= 1'b0; // [R14]
    end else begin
      run_en <= (state_ff == SPL_ST_HOLD);
    end
  end

  // ==========================================================
  // register read port
  // ==========================================================
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SPL_OFS_STRAP: reg_rdata <= {3'h0, strap_ff}; // [R6]
        `SPL_OFS_OVR: reg_rdata <= ovr_ff;
        `SPL_OFS_EFF: reg_rdata <= {3'h0, eff_bits};
        `SPL_OFS_PULL: reg_rdata <= {3'h0, PULL_DEF};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  property p_load_once;
    @(posedge core_clk) disable iff (srst)
      (state_ff == SPL_ST_RESET && !sys_rst) |=> (strap_ff == $past(pins_sync));
  endproperty
  a_load_once: assert property (p_load_once) else $error("strap not loaded"); // [R1]

  property p_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD) |=> $stable(strap_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("strap changed while held"); // [R3]

  property p_pulls;
    @(posedge core_clk) disable iff (srst)
      sys_rst |=> (pull_up_en == PULL_DEF && pull_dn_en == ~PULL_DEF);
  endproperty
  a_pulls: assert property (p_pulls) else $error("default pulls missing"); // [R4]

  property p_normal;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD) |=> pins_normal_func;
  endproperty
  a_normal: assert property (p_normal) else $error("pins not released"); // [R5]

  property p_read;
    @(posedge core_clk) disable iff (srst)
      (reg_rd && reg_addr == `SPL_OFS_STRAP) |=> (reg_rdata[4:0] == $past(strap_ff));
  endproperty
  a_read: assert property (p_read) else $error("strap read wrong"); // [R6]

  property p_vsel;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD && !ovr_ff[`SPL_BIT_OVR_VEN])
        |=> (cfg_out.vsel_1v8 == $past(strap_ff[`SPL_BIT_VSEL]));
  endproperty
  a_vsel: assert property (p_vsel) else $error("voltage select wrong"); // [R7]

  property p_boot;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD && strap_ff[`SPL_BIT_BOOTA]) |=> (cfg_out.boot_src == SPL_BOOT_FLASH);
  endproperty
  a_boot: assert property (p_boot) else $error("flash boot not chosen"); // [R8]

  property p_oedge;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD && ovr_ff[`SPL_BIT_OVR_OEN])
        |=> (cfg_out.sdio_output_rise == $past(ovr_ff[`SPL_BIT_OEDGE]));
  endproperty
  a_oedge: assert property (p_oedge) else $error("edge override ignored"); // [R11]

  property p_en;
    @(posedge core_clk) disable iff (srst)
      !module_en |=> !run_en;
  endproperty
  a_en: assert property (p_en) else $error("runs while disabled"); // [R14]

  // boot logic must see an idle configuration while the module is disabled
  property p_cfg_idle;
    @(posedge core_clk) disable iff (srst)
      (!module_en && state_ff == SPL_ST_RESET) |=> (cfg_out == '0 && !boot_log_en);
  endproperty
  a_cfg_idle: assert property (p_cfg_idle) else $error("config driven while disabled"); // [R14]

  property p_sources;
    @(posedge core_clk) disable iff (srst)
      (por_rst || wdt_rst || bod_rst) |=> (state_ff == SPL_ST_RESET && !run_en);
  endproperty
  a_sources: assert property (p_sources) else $error("reset source ignored"); // [R2]

  property p_release_pulls;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff != SPL_ST_RESET)
        |=> (pull_up_en == 5'h00 && pull_dn_en == 5'h00 && pins_normal_func);
  endproperty
  a_release_pulls: assert property (p_release_pulls) else $error("pulls kept"); // [R5]

  property p_unmapped;
    @(posedge core_clk) disable iff (srst)
      (reg_rd && reg_addr > `SPL_OFS_PULL) |=> (reg_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [R6]

  property p_download;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD && !strap_ff[`SPL_BIT_BOOTA] && !strap_ff[`SPL_BIT_BOOTB])
        |=> (cfg_out.boot_src == SPL_BOOT_DOWNLOAD);
  endproperty
  a_download: assert property (p_download) else $error("download boot not chosen"); // [R8]

  // the log choice ignores the override register on purpose
  property p_log;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD) |=> (boot_log_en == $past(strap_ff[`SPL_BIT_LOG]));
  endproperty
  a_log: assert property (p_log) else $error("boot log enable wrong"); // [R9]

  property p_sample;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD && !ovr_ff[`SPL_BIT_OVR_SEN])
        |=> (cfg_out.sdio_sample_rise == $past(strap_ff[`SPL_BIT_LOG]));
  endproperty
  a_sample: assert property (p_sample) else $error("sample edge wrong"); // [R10]

  property p_oedge_strap;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD && !ovr_ff[`SPL_BIT_OVR_OEN])
        |=> (cfg_out.sdio_output_rise == $past(strap_ff[`SPL_BIT_OEDGE]));
  endproperty
  a_oedge_strap: assert property (p_oedge_strap) else $error("output edge wrong"); // [R10]

  property p_vsel_ovr;
    @(posedge core_clk) disable iff (sys_rst)
      (state_ff == SPL_ST_HOLD && ovr_ff[`SPL_BIT_OVR_VEN])
        |=> (cfg_out.vsel_1v8 == $past(ovr_ff[`SPL_BIT_VSEL]));
  endproperty
  a_vsel_ovr: assert property (p_vsel_ovr) else $error("voltage override ignored"); // [R11]

  // a saturated counter means the release sequence must already be complete
  property p_settled;
    @(posedge core_clk) disable iff (sys_rst)
      (settle_ff == 3'h7) |-> (run_en && pins_normal_func && state_ff == SPL_ST_HOLD);
  endproperty
  a_settled: assert property (p_settled) else $error("release sequence stalled"); // [R15]

  c_download: cover property (@(posedge core_clk) cfg_out.boot_src == SPL_BOOT_DOWNLOAD);
  c_other: cover property (@(posedge core_clk) cfg_out.boot_src == SPL_BOOT_OTHER);
  c_wdt: cover property (@(posedge core_clk) wdt_rst ##1 !wdt_rst ##3 run_en);
  c_ovr: cover property (@(posedge core_clk) reg_wr && reg_addr == `SPL_OFS_OVR);
endmodule : spl_strap_latch

/* File: rtl/spl_sync.sv */
// two-flop synchroniser for a bus of levels
`timescale 1ns/1ns
module spl_sync #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // levels
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    meta_ff <= d_in;
    sync_ff <= meta_ff;
  end
  assign q_out = sync_ff;
endmodule : spl_sync

/* File: shared/spl_pkg.sv */
// types shared by the strap latch files
package spl_pkg;
  typedef struct packed {
    logic output_edge_strap;
    logic log_and_sample_edge_strap;
    logic boot_source_strap_b;
    logic boot_source_strap_a;
    logic supply_voltage_strap;
  } spl_straps_t;
  typedef enum logic [1:0] {
    SPL_BOOT_FLASH = 2'h0,
    SPL_BOOT_DOWNLOAD = 2'h1,
    SPL_BOOT_OTHER = 2'h2
  } spl_boot_t;
  typedef enum logic [1:0] {
    SPL_ST_RESET = 2'h0,
    SPL_ST_LOAD = 2'h1,
    SPL_ST_HOLD = 2'h3
  } spl_state_t;
  typedef struct packed {
    logic vsel_1v8;
    spl_boot_t boot_src;
    logic log_en;
    logic sdio_sample_rise;
    logic sdio_output_rise;
  } spl_cfg_t;
endpackage : spl_pkg

/* File: shared/spl_regs.svh */
// register offsets, field positions and reset values of the strap latch
`ifndef SPL_REGS_SVH
`define SPL_REGS_SVH
`define SPL_ADDR_W 4
`define SPL_OFS_STRAP 4'h0
`define SPL_OFS_OVR 4'h1
`define SPL_OFS_EFF 4'h2
`define SPL_OFS_PULL 4'h3
`define SPL_BIT_VSEL 0
`define SPL_BIT_BOOTA 1
`define SPL_BIT_BOOTB 2
`define SPL_BIT_LOG 3
`define SPL_BIT_OEDGE 4
`define SPL_BIT_OVR_VEN 5
`define SPL_BIT_OVR_SEN 6
`define SPL_BIT_OVR_OEN 7
`define SPL_PULL_DEFAULT 5'h1a
`define SPL_OVR_RESET 8'h00
`endif

/* File: sim/spl_strap_board.sv */
// device pad pulls and host outputs resolving the five strap pads
`timescale 1ns/1ns
module spl_strap_board (
  // clock
  input wire logic core_clk,
  // pad pulls from the device
  input wire logic [4:0] pull_up_en,
  input wire logic [4:0] pull_dn_en,
  // host drive commanded by the bench
  input wire logic [4:0] host_oe,
  input wire logic [4:0] host_val,
  input wire logic allow_vsel_high,
  // resolved pad levels
  output spl_pkg::spl_straps_t strap_in
);
  import spl_pkg::*;
  logic [4:0] lvl_ff;
  logic [4:0] drv;
  logic [4:0] pad;
  // =========================================
  // pad resolution
  // supply strap stays low: the module flash is 3.3 V only, broken only on command
  assign drv = {host_val[4:1], host_val[0] & allow_vsel_high};
  assign strap_in = pad;
  always_ff @(posedge core_clk) begin
    lvl_ff <= pad;
  end
  // an undriven, unpulled pad toggles so a stale level never looks held
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (host_oe[i]) pad[i] = drv[i];
      else if (pull_up_en[i]) pad[i] = 1'b1;
      else if (pull_dn_en[i]) pad[i] = 1'b0;
      else pad[i] = ~lvl_ff[i];
    end
  end
endmodule : spl_strap_board

/* File: sim/tb_top.sv */
// self-checking bench for the strap latch
`timescale 1ns/1ns
`include "spl_regs.svh"
module tb_top;
  import spl_pkg::*;
  logic core_clk;
  logic [4:0] rst_v;
  logic [`SPL_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic [4:0] pull_up_en;
  logic [4:0] pull_dn_en;
  logic [4:0] host_oe;
  logic [4:0] host_val;
  logic relax;
  logic pins_normal_func;
  logic boot_log_en;
  logic run_en;
  spl_straps_t strap_in;
  spl_cfg_t cfg_out;
  int mismatches;
  int checked;
  logic [4:0] pat [5] = '{5'h1a, 5'h00, 5'h04, 5'h0a, 5'h11};
  logic [4:0] oe [5] = '{5'h00, 5'h1f, 5'h1f, 5'h1f, 5'h1f};
  // =========================================
  // instances
  spl_strap_latch spl_strap_latch_inst (.core_clk(core_clk), .srst(rst_v[0]),
    .por_rst(rst_v[1]), .wdt_rst(rst_v[2]), .bod_rst(rst_v[3]), .module_en(~rst_v[4]),
    .strap_in(strap_in), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
    .pins_normal_func(pins_normal_func), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_out(cfg_out),
    .boot_log_en(boot_log_en), .run_en(run_en));
  spl_strap_board spl_strap_board_inst (.core_clk(core_clk), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .host_oe(host_oe), .host_val(host_val),
    .allow_vsel_high(relax), .strap_in(strap_in));
  // =========================================
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd
  function automatic logic [7:0] exp_cfg(input logic [4:0] s);
    spl_boot_t b;
    b = s[1] ? SPL_BOOT_FLASH : (s[2] ? SPL_BOOT_OTHER : SPL_BOOT_DOWNLOAD);
    return {2'h0, s[0], b, s[3], s[3], s[4]};
  endfunction : exp_cfg
  // hold one reset source four cycles so the synchroniser sees the pulled pads
  task automatic boot(input int src, input logic [4:0] o, input logic [4:0] v);
    @(posedge core_clk);
    host_oe <= o;
    host_val <= v;
    relax <= v[0];
    rst_v <= 5'(1 << src);
    repeat (3) @(posedge core_clk);
    #1;
    check({3'h0, pull_up_en}, 8'h1a);
    check({3'h0, pull_dn_en}, 8'h05);
    check({7'h0, pins_normal_func}, 8'h00);
    check({7'h0, run_en}, 8'h00);
    @(posedge core_clk);
    rst_v <= 5'h00;
    repeat (5) @(posedge core_clk);
    #1;
    check({7'h0, pins_normal_func}, 8'h01);
    check({3'h0, pull_up_en | pull_dn_en}, 8'h00);
    check({7'h0, run_en}, 8'h01);
  endtask : boot
  task automatic summarize();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // =========================================
  // stimulus
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
  initial begin
    rst_v = 5'h01;
    reg_addr = '0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    host_oe = 5'h00;
    host_val = 5'h00;
    relax = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      boot(i, oe[i], pat[i]);
      rd(`SPL_OFS_STRAP, {3'h0, pat[i]});
      check({2'h0, cfg_out}, exp_cfg(pat[i]));
      check({7'h0, boot_log_en}, {7'h0, pat[i][3]});
      @(posedge core_clk);
      host_oe <= 5'h1f;
      host_val <= ~pat[i];
      repeat (4) @(posedge core_clk);
      rd(`SPL_OFS_STRAP, {3'h0, pat[i]});
      check({2'h0, cfg_out}, exp_cfg(pat[i]));
    end
    // override voltage high and both sdio edges low; log stays as strapped
    boot(0, 5'h00, 5'h00);
    rd(`SPL_OFS_OVR, `SPL_OVR_RESET);
    wr(`SPL_OFS_OVR, 8'he1);
    rd(`SPL_OFS_OVR, 8'he1);
    rd(`SPL_OFS_EFF, 8'h03);
    check({2'h0, cfg_out}, 8'h24);
    check({7'h0, boot_log_en}, 8'h01);
    wr(`SPL_OFS_STRAP, 8'h00);
    rd(`SPL_OFS_STRAP, 8'h1a);
    rd(`SPL_OFS_PULL, {3'h0, `SPL_PULL_DEFAULT});
    rd(4'hf, 8'h00);
    boot(0, 5'h00, 5'h00);
    rd(`SPL_OFS_OVR, `SPL_OVR_RESET);
    summarize();
  end
endmodule : tb_top
